/* File: verilog/sdx_pkg.sv */
// Purpose: shared constants for the serial diagnostic status block
// Assumes: 100 MHz clock, synchronous active-high reset
// Notes: bit positions follow the reported byte layouts
// How it works
// - response bit 0 while safety outputs on, bit 1 while actuator seen.
// - response bit 4 whenever both safety inputs are energised.
// - marginal zone sets response bit 5 and blinks the yellow lamp at 1 Hz.
// - response bit 6 on pending warning, bit 7 when error forced outputs off.
// - warning and error bytes flag out A, out B, cross, heat, internal fault.
// - error byte bit 4 flags bad actuator; warning byte bit 4 stays zero.
// - warning byte bit 6 flags gateway link failure; error byte bit 6 zero.
// - every status bit is active high, one meaning the condition holds.
// - idle with inputs live: green only, outputs off, response bit 4 only.
// - actuated and enabled: green and yellow lit, outputs on, bits 4,1,0.
// - each status bit follows its own condition; bit 5 is set only while the actuator is also seen.
// - warning keeps outputs on, switching them off after 30 minutes.
// - error clears once cause gone and request bit 7 falls or guard opens.
// - on gateway link failure the safety outputs hold their present state.

package sdx_pkg;

	localparam int CLK_HZ = 100_000_000;
	localparam int BLINK_HZ = 1;
	localparam int HALF_BLINK_CYC = CLK_HZ / (2 * BLINK_HZ);
	localparam int WARN_DELAY_MIN = 30;
	localparam int SEC_PER_MIN = 60;
	// delay counted in half-blink ticks to keep the counter small
	localparam int WARN_DELAY_TICKS = WARN_DELAY_MIN * SEC_PER_MIN * 2 * BLINK_HZ;
	localparam int WARN_CNT_W = 12;
	localparam logic [WARN_CNT_W-1:0] WARN_LAST =
		WARN_CNT_W'(WARN_DELAY_TICKS - 1);

	localparam int BYTE_W = 8;
	localparam int FAULT_W = 6;

	// response byte
	localparam int RSP_OUT_ON = 0;
	localparam int RSP_ACT = 1;
	localparam int RSP_INPUTS = 4;
	localparam int RSP_MARGIN = 5;
	localparam int RSP_WARN = 6;
	localparam int RSP_ERR = 7;
	localparam int REQ_ERR_CLR = 7;

	// warning and error bytes
	localparam int DG_OUT_A = 0;
	localparam int DG_OUT_B = 1;
	localparam int DG_CROSS = 2;
	localparam int DG_TEMP = 3;
	localparam int DG_ACTUATOR = 4;
	localparam int DG_INTERNAL = 5;
	localparam int DG_COMM = 6;
	localparam logic [BYTE_W-1:0] WARN_CAUSE_MASK = 8'h2F;
	localparam logic [BYTE_W-1:0] ERR_MASK = 8'h3F;
	localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;

	// synchroniser lanes; faults occupy 0..5 in diagnostic order
	localparam int SY_COMM = 6;
	localparam int SY_IN_A = 7;
	localparam int SY_IN_B = 8;
	localparam int SY_ACT = 9;
	localparam int SY_MARGIN = 10;
	localparam int SY_REQ = 11;
	localparam int SYNC_W = 12;

	typedef enum logic [2:0] {
		ST_RUN = 3'b001,
		ST_WARN = 3'b010,
		ST_FAULT = 3'b100
	} sdx_state_t;

endpackage

/* File: verilog/sdx_sync.sv */
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: inputs asynchronous to clk
// Notes: output moves only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module sdx_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_lane
			logic s1;
			logic s2;
			logic s3;
			logic next_q;

			always_comb begin
				next_q = (s2 == s3) ? s3 : q[i];
			end

			always_ff @(posedge clk) begin
				if (rst) begin
					s1 <= 1'b0;
					s2 <= 1'b0;
					s3 <= 1'b0;
					q[i] <= 1'b0;
				end else begin
					s1 <= d[i];
					s2 <= s1;
					s3 <= s2;
					q[i] <= next_q;
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

/* File: verilog/sdx_timebase.sv */
// Purpose: half-period tick and blink phase for lamps and delays
// Assumes: HALF_CYC of at least two
// Notes: tick is one cycle wide, phase toggles on each tick
`timescale 1ns/1ps
`default_nettype none

module sdx_timebase #(
	parameter int HALF_CYC = 50_000_000
) (
	input wire logic clk,
	input wire logic rst,
	output logic tick,
	output logic phase
);

	localparam logic [31:0] LAST = 32'(HALF_CYC - 1);

	logic [31:0] cnt;
	logic [31:0] next_cnt;
	logic next_tick;
	logic next_phase;

	always_comb begin
		next_tick = (cnt == LAST);
		next_cnt = next_tick ? 32'h0000_0000 : cnt + 32'h0000_0001;
		next_phase = next_tick ? ~phase : phase;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt <= 32'h0000_0000;
			tick <= 1'b0;
			phase <= 1'b0;
		end else begin
			cnt <= next_cnt;
			tick <= next_tick;
			phase <= next_phase;
		end
	end

endmodule

`default_nettype wire

/* File: verilog/sdx_diag.sv */
// Purpose: status, warning and error bytes, lamps and safety outputs
// Assumes: condition inputs come from pins or other clocks
// Notes: warning escalates to error after a long delay
`timescale 1ns/1ps
`default_nettype none

module sdx_diag
	import sdx_pkg::*;
#(
	parameter int HALF_BLINK_CYCLES = HALF_BLINK_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic safety_in_a,
	input wire logic safety_in_b,
	input wire logic actuator_present,
	input wire logic actuator_marginal,
	input wire logic fault_out_a,
	input wire logic fault_out_b,
	input wire logic fault_cross,
	input wire logic fault_overtemp,
	input wire logic fault_actuator,
	input wire logic fault_internal,
	input wire logic comm_fail,
	input wire logic [BYTE_W-1:0] request_control_byte,
	output logic [BYTE_W-1:0] response_status_byte,
	output logic [BYTE_W-1:0] warning_diag_byte,
	output logic [BYTE_W-1:0] error_diag_byte,
	output logic safety_out_a,
	output logic safety_out_b,
	output logic lamp_green,
	output logic lamp_red,
	output logic lamp_yellow
);

	logic [SYNC_W-1:0] raw;
	logic [SYNC_W-1:0] s;
	logic tick;
	logic phase;

	// only the clear bit is carried; the rest of the request is unused
	assign raw = {request_control_byte[REQ_ERR_CLR], actuator_marginal,
		actuator_present, safety_in_b, safety_in_a, comm_fail,
		fault_internal, fault_actuator, fault_overtemp, fault_cross,
		fault_out_b, fault_out_a};

	sdx_sync #(
		.W(SYNC_W)
	) u_sync (
		.clk(clk),
		.rst(rst),
		.d(raw),
		.q(s)
	);

	sdx_timebase #(
		.HALF_CYC(HALF_BLINK_CYCLES)
	) u_tb (
		.clk(clk),
		.rst(rst),
		.tick(tick),
		.phase(phase)
	);

	sdx_state_t state;
	sdx_state_t next_state;
	logic [WARN_CNT_W-1:0] warn_cnt;
	logic [WARN_CNT_W-1:0] next_warn_cnt;
	logic req_q;
	logic act_q;
	logic [BYTE_W-1:0] next_resp;
	logic [BYTE_W-1:0] next_warn;
	logic [BYTE_W-1:0] next_err;
	logic next_out;
	logic next_green;
	logic next_red;
	logic next_yellow;

	logic [BYTE_W-1:0] cause;
	logic [BYTE_W-1:0] err_set;
	logic pending;
	logic expire;
	logic clear_evt;
	logic inputs_live;
	logic want_on;

	always_comb begin
		cause = {2'b00, s[FAULT_W-1:0]};
		pending = |(cause & WARN_CAUSE_MASK);
		inputs_live = s[SY_IN_A] & s[SY_IN_B];
		// clear on falling request bit or guard opening
		clear_evt = (req_q & ~s[SY_REQ]) | (act_q & ~s[SY_ACT]);

		expire = (state == ST_WARN) && pending && tick &&
			(warn_cnt == WARN_LAST);
		if ((state == ST_WARN) && pending) begin
			next_warn_cnt = tick ? warn_cnt + 1'b1 : warn_cnt;
		end else begin
			next_warn_cnt = '0;
		end

		// bad actuator latches at once, others only on expiry
		err_set = cause & ERR_MASK & ~WARN_CAUSE_MASK;
		if (expire) begin
			err_set = err_set | (cause & WARN_CAUSE_MASK);
		end
		// set wins over a clear in the same cycle
		next_err = err_set |
			(error_diag_byte & ~({BYTE_W{clear_evt}} & ~cause));

		case (state)
			ST_RUN: begin
				if (next_err != BYTE_ZERO) begin
					next_state = ST_FAULT;
				end else if (pending) begin
					next_state = ST_WARN;
				end else begin
					next_state = ST_RUN;
				end
			end
			ST_WARN: begin
				if (next_err != BYTE_ZERO) begin
					next_state = ST_FAULT;
				end else if (!pending) begin
					next_state = ST_RUN;
				end else begin
					next_state = ST_WARN;
				end
			end
			ST_FAULT: begin
				if (next_err != BYTE_ZERO) begin
					next_state = ST_FAULT;
				end else if (pending) begin
					next_state = ST_WARN;
				end else begin
					next_state = ST_RUN;
				end
			end
			default: begin
				next_state = ST_RUN;
			end
		endcase

		// any latched error forces the outputs off
		want_on = inputs_live & s[SY_ACT] & (next_err == BYTE_ZERO);
		// link failure freezes the switching state
		next_out = s[SY_COMM] ? safety_out_a : want_on;

		// each bit from its own condition
		next_resp = BYTE_ZERO;
		next_resp[RSP_OUT_ON] = next_out;
		next_resp[RSP_ACT] = s[SY_ACT];
		next_resp[RSP_INPUTS] = inputs_live;
		next_resp[RSP_MARGIN] = s[SY_ACT] & s[SY_MARGIN];
		next_resp[RSP_WARN] = pending;
		next_resp[RSP_ERR] = |next_err;

		// link failure is a warning only
		next_warn = cause & WARN_CAUSE_MASK;
		next_warn[DG_COMM] = s[SY_COMM];

		next_green = ~pending & (next_err == BYTE_ZERO);
		next_red = pending | (next_err != BYTE_ZERO);
		// yellow blinks in the marginal zone
		next_yellow = s[SY_ACT] & (~s[SY_MARGIN] | phase);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state <= ST_RUN;
			warn_cnt <= '0;
			req_q <= 1'b0;
			act_q <= 1'b0;
			response_status_byte <= BYTE_ZERO;
			warning_diag_byte <= BYTE_ZERO;
			error_diag_byte <= BYTE_ZERO;
			safety_out_a <= 1'b0;
			safety_out_b <= 1'b0;
			lamp_green <= 1'b0;
			lamp_red <= 1'b0;
			lamp_yellow <= 1'b0;
		end else begin
			state <= next_state;
			warn_cnt <= next_warn_cnt;
			req_q <= s[SY_REQ];
			act_q <= s[SY_ACT];
			response_status_byte <= next_resp;
			warning_diag_byte <= next_warn;
			error_diag_byte <= next_err;
			safety_out_a <= next_out;
			safety_out_b <= next_out;
			lamp_green <= next_green;
			lamp_red <= next_red;
			lamp_yellow <= next_yellow;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	AST_RSP_SPARE_ZERO: assert property (
		response_status_byte[3:2] == 2'b00
	) else $error("response spare bits set");

	AST_OUT_BIT_TRACKS: assert property (
		response_status_byte[RSP_OUT_ON] == safety_out_a &&
		safety_out_a == safety_out_b
	) else $error("output bit disagrees with safety outputs");

	AST_ERR_OUTS_OFF: assert property (
		response_status_byte[RSP_ERR] |-> !safety_out_a ||
		$past(s[SY_COMM])
	) else $error("outputs on during error");

	AST_INPUTS_BIT: assert property (
		(s[SY_IN_A] && s[SY_IN_B]) |=> response_status_byte[RSP_INPUTS]
	) else $error("inputs bit missing");

	AST_MARGIN_BIT: assert property (
		(s[SY_ACT] && s[SY_MARGIN]) |=>
		response_status_byte[RSP_MARGIN] && response_status_byte[RSP_ACT]
	) else $error("marginal bit missing");

	AST_WARN_KEEPS_ON: assert property (
		(state == ST_WARN && pending && safety_out_a && !expire &&
		want_on && !s[SY_COMM]) |=> safety_out_a &&
		response_status_byte[RSP_WARN]
	) else $error("warning switched outputs off early");

	AST_EXPIRE_ERR: assert property (
		expire |=> state == ST_FAULT &&
		(error_diag_byte & WARN_CAUSE_MASK) != BYTE_ZERO ##1
		!safety_out_a || $past(s[SY_COMM])
	) else $error("delay expiry did not raise error");

	AST_COMM_HOLD: assert property (
		s[SY_COMM] |=> $stable(safety_out_a)
	) else $error("outputs changed during link failure");

	AST_CLEAR_ERR: assert property (
		(error_diag_byte != BYTE_ZERO && clear_evt &&
		cause == BYTE_ZERO) |=> error_diag_byte == BYTE_ZERO
	) else $error("error not cleared");

	AST_ACT_ERR: assert property (
		s[DG_ACTUATOR] |=> error_diag_byte[DG_ACTUATOR] &&
		!warning_diag_byte[DG_ACTUATOR]
	) else $error("actuator error not flagged");

	AST_COMM_WARN: assert property (
		s[SY_COMM] |=> warning_diag_byte[DG_COMM] &&
		!error_diag_byte[DG_COMM]
	) else $error("link failure not flagged");

	AST_IDLE_LAMPS: assert property (
		(inputs_live && !s[SY_ACT] && !pending &&
		next_err == BYTE_ZERO && !s[SY_COMM]) |=>
		lamp_green && !lamp_red && !lamp_yellow &&
		!safety_out_a && response_status_byte[RSP_INPUTS]
	) else $error("idle pattern wrong");

	AST_ACTUATED_ON: assert property (
		(want_on && !s[SY_COMM] && !s[SY_MARGIN]) |=>
		safety_out_a && lamp_yellow &&
		response_status_byte[RSP_ACT] && response_status_byte[RSP_OUT_ON]
	) else $error("actuated pattern wrong");

	AST_INPUTS_OFF: assert property (
		(!inputs_live && !s[SY_COMM]) |=> !safety_out_a
	) else $error("outputs on without both inputs");

	AST_FAULT_WARN: assert property (
		(s[DG_OUT_A] || s[DG_TEMP] || s[DG_INTERNAL]) |=>
		response_status_byte[RSP_WARN] && lamp_red && !lamp_green
	) else $error("warning cause not reported");

	AST_CROSS_BIT: assert property (
		s[DG_CROSS] |=> warning_diag_byte[DG_CROSS]
	) else $error("cross fault bit missing");

	AST_WARN_SPARE: assert property (
		!warning_diag_byte[DG_ACTUATOR] &&
		!warning_diag_byte[BYTE_W-1]
	) else $error("warning spare bits set");

	AST_ERR_SPARE: assert property (
		!error_diag_byte[DG_COMM] && !error_diag_byte[BYTE_W-1]
	) else $error("error spare bits set");

	AST_NO_COND_ZERO: assert property (
		(!inputs_live && !s[SY_ACT]) |=>
		!response_status_byte[RSP_INPUTS] &&
		!response_status_byte[RSP_ACT] &&
		!response_status_byte[RSP_MARGIN] && !lamp_yellow
	) else $error("status bit set without its condition");

	AST_NO_EARLY_ERR: assert property (
		(!expire && !s[DG_ACTUATOR] &&
		error_diag_byte == BYTE_ZERO) |=> error_diag_byte == BYTE_ZERO
	) else $error("error raised before delay expiry");

endmodule

`default_nettype wire

/* File: dv/sdx_gw_model.sv */
// Purpose: gateway side of the diagnostic link, drives the request byte
// Assumes: bench calls clear_error to ask for an error reset
// Notes: unused request bits carry a filler pattern, never zero
`timescale 1ns/1ps
`default_nettype none

module sdx_gw_model
	import sdx_pkg::*;
(
	input wire logic clk,
	output logic [BYTE_W-1:0] request_control_byte
);
	logic clr_bit;

	// only bit 7 meaningful
	// filler in the low bits shows that they are ignored
	assign request_control_byte = {clr_bit, 7'h5A};

	initial begin
		clr_bit = 1'b0;
	end

	// raise then lower
	// each level held past the input filter
	task automatic clear_error();
		@(posedge clk);
		#1 clr_bit = 1'b1;
		repeat (4) @(posedge clk);
		#1 clr_bit = 1'b0;
		repeat (8) @(posedge clk);
		#1;
	endtask

endmodule
`default_nettype wire

/* File: dv/tb_sdx_diag.sv */
// Purpose: self-checking bench for the diagnostic status block
// Assumes: blink half period shortened to four cycles
// Notes: condition pins packed in one word for compact stimulus
`timescale 1ns/1ps
`default_nettype none

module tb_sdx_diag;
	import sdx_pkg::*;
	localparam int HB = 4;
	localparam int IA = 1, IB = 2, AC = 4, MG = 8, FT = 128;
	localparam int FA = 256, CM = 1024;
	logic clk, rst;
	logic [10:0] c;
	logic [BYTE_W-1:0] req, rsp, wrn, err;
	logic out_a, out_b, grn, red, yel, y0;
	int n_errors, checks_done;
	int fpin[5] = '{16, 32, 64, 128, 512};
	int fbit[5] = '{0, 1, 2, 3, 5};

	sdx_gw_model sdx_gw_model_inst (.clk(clk), .request_control_byte(req));

	sdx_diag #(.HALF_BLINK_CYCLES(HB)) sdx_diag_inst (
		.clk(clk), .rst(rst),
		.safety_in_a(c[0]), .safety_in_b(c[1]),
		.actuator_present(c[2]), .actuator_marginal(c[3]),
		.fault_out_a(c[4]), .fault_out_b(c[5]), .fault_cross(c[6]),
		.fault_overtemp(c[7]), .fault_actuator(c[8]),
		.fault_internal(c[9]), .comm_fail(c[10]),
		.request_control_byte(req), .response_status_byte(rsp),
		.warning_diag_byte(wrn), .error_diag_byte(err),
		.safety_out_a(out_a), .safety_out_b(out_b),
		.lamp_green(grn), .lamp_red(red), .lamp_yellow(yel)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic results();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// pins change just after an edge, then outputs get time to follow
	task automatic go(input int v);
		@(posedge clk);
		#1 c = v[10:0];
		repeat (8) @(posedge clk);
		#1;
	endtask

	task automatic lamps(input logic [2:0] exp);
		check({5'h00, grn, red, yel}, {5'h00, exp});
	endtask

	task automatic outs(input logic exp);
		check({6'h00, out_a, out_b}, {6'h00, exp, exp});
	endtask

	initial begin
		n_errors = 0;
		checks_done = 0;
		rst = 1'b1;
		c = '0;
		repeat (10) @(posedge clk);
		#1 rst = 1'b0;
		check(rsp, 8'h00);
		go(IA | IB);
		check(rsp, 8'h10);
		lamps(3'b100);
		outs(1'b0);
		go(IA | IB | AC);
		check(rsp, 8'h13);
		lamps(3'b101);
		outs(1'b1);
		go(IA | IB | AC | MG);
		check(rsp, 8'h33);
		y0 = yel;
		repeat (HB) @(posedge clk);
		#1;
		check({7'h00, yel}, {7'h00, ~y0});
		go(IA | AC);
		check(rsp, 8'h02);
		for (int i = 0; i < 5; i++) begin
			go(IA | IB | AC | fpin[i]);
			check(wrn, 8'(1 << fbit[i]));
			check(rsp, 8'h53);
			check({7'h00, red}, 8'h01);
			outs(1'b1);
		end
		go(IA | IB | AC | CM);
		check(wrn, 8'h40);
		check(err, 8'h00);
		go(IA | IB | CM);
		outs(1'b1);
		go(IA | IB);
		outs(1'b0);
		go(IA | IB | AC | FA);
		check(err, 8'h10);
		check(wrn, 8'h00);
		check(rsp & 8'h83, 8'h82);
		outs(1'b0);
		sdx_gw_model_inst.clear_error();
		check(err, 8'h10);
		go(IA | IB | AC);
		sdx_gw_model_inst.clear_error();
		check(err, 8'h00);
		check(rsp, 8'h13);
		go(IA | IB | AC | FT);
		repeat (3600 * HB - 30) @(posedge clk);
		#1;
		check(err, 8'h00);
		outs(1'b1);
		repeat (60) @(posedge clk);
		#1;
		check(err, 8'h08);
		check(rsp & 8'h81, 8'h80);
		outs(1'b0);
		go(IA | IB);
		check(err, 8'h00);
		go(IA | IB | AC);
		check(rsp, 8'h13);
		results();
	end

	initial begin
		repeat (30000) @(posedge clk);
		n_errors++;
		results();
	end

endmodule
`default_nettype wire
